// *** design/dsp_out_stage.sv ***
// Adder/output stage: first-level units, accumulators, summation, output mux and registers.
`timescale 1ns/1ps
`include "dsp_out_defines.svh"

module dsp_out_stage (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire dsp_out_pkg::apb_req_s apb,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  input  wire dsp_out_pkg::prod_t   prod,
  input  wire logic [3:0]           ena,
  input  wire logic [3:0]           aclr,
  input  wire logic                 sign_a,
  input  wire logic                 sign_b,
  input  wire logic [1:0]           addnsub,
  input  wire logic [1:0]           accum_sload,
  output dsp_out_pkg::lanes_t       result,
  output logic [1:0]                overflow,
  output logic                      chain_ok
);
  import dsp_out_pkg::*;

  cfg_s            ctrl_q;
  logic            pready_q;
  logic [31:0]     prdata_q;
  logic            pslverr_q;
  lanes_t          result_q;
  lanes_t          mux_d;
  logic [1:0]      ovf_q;
  logic [1:0]      ovf_d;
  logic            chain_q;
  logic [3:0]      ctl_s1_q;
  logic [3:0]      ctl_s2_q;
  logic [1:0]      sgn_s1_q;
  logic [1:0]      sgn_s2_q;
  logic [3:0]      ctl;
  logic [1:0]      sgn;
  logic            en_sel;
  logic            clr_sel;
  logic            oreg_eff;
  logic            wr_en;
  logic [71:0]     wide_q;
  logic [71:0]     wide_d;
  logic [71:0]     wide_src;
  logic [51:0]     u18 [2];
  logic [51:0]     u9 [4];
  logic [51:0]     acc_d [2];
  logic            psg;

  assign pready   = pready_q;
  assign prdata   = prdata_q;
  assign pslverr  = pslverr_q;
  assign result   = result_q;
  assign overflow = ovf_q;
  assign chain_ok = chain_q;

  // Sign- or zero-extends an 18-bit 9x9 product.
  function automatic logic [51:0] ext18(input logic [17:0] v, input logic s);
    ext18 = s ? {{34{v[17]}}, v} : {34'h0, v};
  endfunction

  // Sign- or zero-extends a 36-bit 18x18 product.
  function automatic logic [51:0] ext36(input logic [35:0] v, input logic s);
    ext36 = s ? {{16{v[35]}}, v} : {16'h0, v};
  endfunction

  function automatic logic [71:0] ext72(input logic [35:0] v, input logic s);
    ext72 = s ? {{36{v[35]}}, v} : {36'h0, v};
  endfunction

  // APB slave: one wait state, so every access completes on its second access-phase edge.
  assign wr_en = apb.psel & apb.penable & pready_q & apb.pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= apb.psel & apb.penable & ~pready_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= cfg_s'(`CTRL_RESET);
    end else if (wr_en && apb.paddr == `ADDR_CTRL) begin
      ctrl_q.mode      <= mode_e'(apb.pwdata[`F_MODE +: 2]); // RULE_14
      ctrl_q.oreg      <= apb.pwdata[`F_OREG];
      ctrl_q.ctl_stg   <= apb.pwdata[`F_CTL_STG +: 2];
      ctrl_q.sgn_stg   <= apb.pwdata[`F_SGN_STG +: 2];
      ctrl_q.set_sel   <= apb.pwdata[`F_SET_SEL +: 2];
      ctrl_q.wide_pipe <= apb.pwdata[`F_WIDE_PIPE];
      case (apb.pwdata[`F_WIDTH +: 2])
        2'h0: ctrl_q.width <= W_9;
        2'h2: ctrl_q.width <= W_36;
        default: ctrl_q.width <= W_18;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
    end else if (apb.psel && apb.penable && !pready_q) begin
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
      if (apb.paddr == `ADDR_CTRL) begin
        prdata_q <= {20'h0, ctrl_q};
      end else if (apb.paddr == `ADDR_STATUS) begin
        prdata_q <= {28'h0, chain_q, oreg_eff, ovf_q};
      end else if (apb.paddr >= `ADDR_RES_LO && apb.paddr <= `ADDR_RES_HI && apb.paddr[1:0] == 2'h0) begin
        if (apb.paddr[2]) begin
          prdata_q <= {12'h0, result_q[apb.paddr[4:3] - 2'h2][51:32]};
        end else begin
          prdata_q <= result_q[apb.paddr[4:3] - 2'h2][31:0];
        end
      end else begin
        pslverr_q <= 1'b1;
      end
    end
  end

  // The output register is forced on whenever the stage accumulates.
  assign oreg_eff = ctrl_q.oreg | (ctrl_q.mode == MODE_MAC); // RULE_01
  assign en_sel   = ena[ctrl_q.set_sel]; // RULE_13
  assign clr_sel  = aclr[ctrl_q.set_sel]; // RULE_13

  // Control delay lines advance with the selected enable, like the data they track.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_s1_q <= 4'h0;
      ctl_s2_q <= 4'h0;
      sgn_s1_q <= 2'h0;
      sgn_s2_q <= 2'h0;
    end else if (clr_sel) begin
      ctl_s1_q <= 4'h0;
      ctl_s2_q <= 4'h0;
      sgn_s1_q <= 2'h0;
      sgn_s2_q <= 2'h0;
    end else if (en_sel) begin
      ctl_s1_q <= {accum_sload, addnsub}; // RULE_05
      ctl_s2_q <= ctl_s1_q; // RULE_05
      sgn_s1_q <= {sign_b, sign_a}; // RULE_06
      sgn_s2_q <= sgn_s1_q; // RULE_06
    end
  end

  always_comb begin
    case (ctrl_q.ctl_stg)
      2'h0: ctl = {accum_sload, addnsub}; // RULE_05
      2'h1: ctl = ctl_s1_q;
      default: ctl = ctl_s2_q;
    endcase
    case (ctrl_q.sgn_stg)
      2'h0: sgn = {sign_b, sign_a}; // RULE_06
      2'h1: sgn = sgn_s1_q;
      default: sgn = sgn_s2_q;
    endcase
  end

  // A product is signed when either operand is signed.
  assign psg = sgn[0] | sgn[1];

  // First-level units; 18x18 uses two, 9x9 uses four with one select per pair.
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      u18[k] = ctl[k] ? ext36(prod[2*k], psg) + ext36(prod[2*k+1], psg) // RULE_03
                      : ext36(prod[2*k], psg) - ext36(prod[2*k+1], psg); // RULE_04
    end
    for (int k = 0; k < 4; k++) begin
      u9[k] = ctl[k/2] ? ext18(prod[k][17:0], psg) + ext18(prod[k][35:18], psg) // RULE_11
                       : ext18(prod[k][17:0], psg) - ext18(prod[k][35:18], psg); // RULE_04
    end
  end

  // Accumulators fed by the second and fourth products, with registered feedback.
  always_comb begin
    logic [52:0] x;
    logic [52:0] y;
    logic [52:0] r;
    x = 53'h0;
    y = 53'h0;
    r = 53'h0;
    for (int i = 0; i < 2; i++) begin
      x = ctl[2+i] ? 53'h0 : {psg & result_q[i][51], result_q[i]}; // RULE_07
      y = {psg & prod[2*i+1][35], ext36(prod[2*i+1], psg)}; // RULE_18
      r = ctl[i] ? x + y : x - y; // RULE_23
      acc_d[i] = r[51:0]; // RULE_19
      if (ctl[2+i]) begin
        acc_d[i] = ext36(prod[2*i+1], psg); // RULE_08
        ovf_d[i] = 1'b0;
      end else if (psg) begin
        ovf_d[i] = r[52] ^ r[51]; // RULE_20
      end else begin
        ovf_d[i] = r[52]; // RULE_09
      end
    end
  end

  // Final stage of the wide multiply: hi*hi, cross terms and lo*lo aligned and summed.
  assign wide_d = (ext72(prod[3], psg) << 36)
                + ((ext72(prod[1], sgn[0]) + ext72(prod[2], sgn[1])) << 18)
                + ext72(prod[0], 1'b0); // RULE_16

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wide_q <= 72'h0;
    end else if (clr_sel) begin
      wide_q <= 72'h0;
    end else if (en_sel) begin
      wide_q <= wide_d; // RULE_17
    end
  end

  assign wide_src = ctrl_q.wide_pipe ? wide_q : wide_d; // RULE_17

  // Output selection; besides the result_q accumulator feedback, only products from the multiplier ports reach the adders.
  always_comb begin
    mux_d = '0; // RULE_02
    case (ctrl_q.mode)
      MODE_SIMPLE: begin
        if (ctrl_q.width == W_36) begin
          mux_d[0] = {16'h0, wide_src[35:0]};
          mux_d[1] = {16'h0, wide_src[71:36]};
        end else begin
          for (int k = 0; k < 4; k++) begin
            mux_d[k] = {16'h0, prod[k]}; // RULE_15
          end
        end
      end
      MODE_MAC: begin
        mux_d[0] = acc_d[0]; // RULE_18
        mux_d[1] = acc_d[1];
      end
      MODE_TWO_ADD: begin
        if (ctrl_q.width == W_9) begin
          for (int k = 0; k < 4; k++) begin
            mux_d[k] = u9[k]; // RULE_21
          end
        end else begin
          mux_d[0] = u18[0]; // RULE_22
          mux_d[1] = u18[1]; // RULE_21
        end
      end
      default: begin
        if (ctrl_q.width == W_9) begin
          mux_d[0] = u9[0] + u9[1]; // RULE_10
          mux_d[1] = u9[2] + u9[3]; // RULE_11
        end else begin
          mux_d[0] = u18[0] + u18[1]; // RULE_10
        end
      end
    endcase
  end

  // Unregistered mode samples every clock; registered mode obeys the chosen clear/enable set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= '0;
    end else if (!oreg_eff) begin
      result_q <= mux_d; // RULE_12
    end else if (clr_sel) begin
      result_q <= '0; // RULE_13
    end else if (en_sel) begin
      result_q <= mux_d; // RULE_12
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_q <= 2'h0;
    end else if (ctrl_q.mode != MODE_MAC || clr_sel) begin
      ovf_q <= 2'h0; // RULE_20
    end else if (en_sel) begin
      ovf_q <= ovf_d; // RULE_09
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chain_q <= 1'b1;
    end else begin
      chain_q <= (ctrl_q.width != W_36); // RULE_16
    end
  end

endmodule

// *** design/dsp_out_defines.svh ***
// Register map, field positions, reset values and widths of the adder/output stage.
// What this block does
// RULE_01: Accumulator mode always uses the output register; elsewhere it is optional.
// RULE_02: Only own multiplier products enter the stage; no standalone adder operands.
// RULE_03: A high add/subtract select adds, a low one subtracts.
// RULE_04: Two selects; 18x18 one per unit, 9x9 one per upper or lower pair.
// RULE_05: Add/subtract and load selects pass through zero, one or two stages.
// RULE_06: Signedness controls come from the multiplier set, delayed up to two stages.
// RULE_07: In accumulate mode the registered output feeds back as an operand.
// RULE_08: An asserted load replaces the accumulator with the product; one per accumulator.
// RULE_09: Each accumulator has a registered, non-sticky overflow flag.
// RULE_10: Summation adds first-level outputs; two sums of four in 9x9, one in 18x18.
// RULE_11: 9x9 has four first-level units and two summations; 18x18 two and one.
// RULE_12: Output mux picks products, first-level results or sums by mode.
// RULE_13: Output register uses one selectable set of four clear/enable sets.
// RULE_14: Exactly one of four modes for the whole block, never mixed.
// RULE_15: Simple mode drives four 18x18 or eight 9x9 products out.
// RULE_16: 36x36 multiply combines four 18x18 products; input chaining then unavailable.
// RULE_17: In 36x36 mode a separate wide register, switched on by wide_pipe, serves as an internal pipeline stage.
// RULE_18: Accumulate mode uses only the second and fourth multipliers, one or two accumulators.
// RULE_19: Accumulator is 52 bits: 36-bit product plus 16 bits of headroom.
// RULE_20: Load and overflow act only in accumulate mode; subtract gives underflow reports.
// RULE_21: Two-multiplier mode gives two 18x18 or four 9x9 pair sums or differences.
// RULE_22: Complex product: subtractor gives real part, adder gives imaginary part.
// RULE_23: While not loading, accumulator adds or subtracts the product, honouring signedness.
`ifndef DSP_OUT_DEFINES_SVH
`define DSP_OUT_DEFINES_SVH

`define ADDR_CTRL     12'h000
`define ADDR_STATUS   12'h004
`define ADDR_RES_LO   12'h010
`define ADDR_RES_HI   12'h02c

`define F_MODE        0
`define F_WIDTH       2
`define F_OREG        4
`define F_CTL_STG     5
`define F_SGN_STG     7
`define F_SET_SEL     9
`define F_WIDE_PIPE   11

`define CTRL_RESET    12'h004
`define ACC_W         52
`define PROD_W        36
`define HALF_W        18
`define WIDE_W        72

`endif

// *** design/dsp_out_pkg.sv ***
// Types shared by the adder/output stage.
package dsp_out_pkg;
  typedef enum logic [1:0] {MODE_SIMPLE, MODE_MAC, MODE_TWO_ADD, MODE_FOUR_ADD} mode_e;
  typedef enum logic [1:0] {W_9, W_18, W_36} width_e;

  typedef struct packed {
    logic       wide_pipe;
    logic [1:0] set_sel;
    logic [1:0] sgn_stg;
    logic [1:0] ctl_stg;
    logic       oreg;
    width_e     width;
    mode_e      mode;
  } cfg_s;

  typedef logic [3:0][35:0] prod_t;
  typedef logic [3:0][51:0] lanes_t;

  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;
endpackage

// *** tb/dsp_out_monitor.sv ***
// Concurrent checks on the ports of the adder/output stage.
`timescale 1ns/1ps
module dsp_out_monitor (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire dsp_out_pkg::apb_req_s apb,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire dsp_out_pkg::prod_t    prod,
  input wire logic [3:0]            ena,
  input wire logic [3:0]            aclr,
  input wire logic                  sign_a,
  input wire logic                  sign_b,
  input wire logic [1:0]            addnsub,
  input wire logic [1:0]            accum_sload,
  input wire dsp_out_pkg::lanes_t   result,
  input wire logic [1:0]            overflow,
  input wire logic                  chain_ok
);
  import dsp_out_pkg::*;
  logic [11:0] cfg_q;
  logic        chg_q, up_q, wr_w, ok_w, mac_w, two_w, one_w;
  assign wr_w = apb.psel && apb.penable && pready && apb.pwrite && apb.paddr == 12'h000;
  assign ok_w = up_q && !chg_q;
  assign mac_w = cfg_q[10:0] == 11'h005;
  assign two_w = cfg_q[10:0] == 11'h006;
  assign one_w = cfg_q[10:0] == 11'h004;
  // Shadow of the control word; checks apply once a new mode has settled.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= 12'h004;
      chg_q <= 1'b0;
      up_q <= 1'b0;
    end else begin
      up_q <= 1'b1;
      chg_q <= wr_w;
      if (wr_w) begin
        cfg_q <= apb.pwdata[11:0];
      end
    end
  end
  function automatic logic [51:0] z(logic [35:0] p);
    return {16'h0000, p};
  endfunction
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_wait: assert property (apb.psel && !apb.penable |=> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_simple_pass: assert property (ok_w && one_w && !$past(sign_a | sign_b)
    |-> result[0] == z($past(prod[0])) && result[3] == z($past(prod[3])))
    else $error("simple lane differs from product");
  a_two_add: assert property (ok_w && two_w && !$past(sign_a | sign_b)
    |-> result[1] == ($past(addnsub[1]) ? z($past(prod[2])) + z($past(prod[3]))
                                         : z($past(prod[2])) - z($past(prod[3]))))
    else $error("pair sum wrong");
  a_mac_load: assert property (ok_w && mac_w
    && $past(accum_sload[0] && ena[0] && !aclr[0] && !sign_a && !sign_b)
    |-> result[0] == z($past(prod[1])) && !overflow[0])
    else $error("load did not take product");
  a_mac_accum: assert property (ok_w && mac_w
    && $past(ena[0] && addnsub[0] && !accum_sload[0] && !aclr[0] && !sign_a && !sign_b)
    |-> result[0] == $past(result[0]) + z($past(prod[1])))
    else $error("accumulate sum wrong");
  a_mac_hold: assert property (ok_w && mac_w && $past(!ena[0] && !aclr[0]) |-> $stable(result[0]))
    else $error("accumulator moved while disabled");
  a_ovf_idle: assert property (ok_w && cfg_q[1:0] != 2'd1 |-> overflow == 2'b00)
    else $error("overflow outside accumulate mode");
  a_chain_flag: assert property (ok_w |-> chain_ok == (cfg_q[3:2] != 2'd2))
    else $error("chain flag wrong for width");
  c_mac_load: cover property (ok_w && mac_w && accum_sload[0]);
  c_two_add: cover property (ok_w && two_w);
  c_bad_addr: cover property (pready && pslverr);
endmodule
bind dsp_out_stage dsp_out_monitor dsp_out_monitor_i (.pclk(pclk), .presetn(presetn), .apb(apb), .pready(pready),
  .pslverr(pslverr), .prod(prod), .ena(ena), .aclr(aclr), .sign_a(sign_a), .sign_b(sign_b), .addnsub(addnsub),
  .accum_sload(accum_sload), .result(result), .overflow(overflow), .chain_ok(chain_ok));

// *** tb/mult_src.sv ***
// Behavioural multiplier sub-blocks that feed products to the stage.
`timescale 1ns/1ps
module mult_src (
  input  wire logic [3:0][17:0] a,
  input  wire logic [3:0][17:0] b,
  input  wire logic             sign_a,
  input  wire logic             sign_b,
  output dsp_out_pkg::prod_t    prod
);
  import dsp_out_pkg::*;
  logic signed [37:0] full [4];
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      full[k] = $signed({sign_a & a[k][17], a[k]}) * $signed({sign_b & b[k][17], b[k]});
      prod[k] = full[k][35:0];
    end
  end
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the adder/output stage.
`timescale 1ns/1ps
module testbench;
  import dsp_out_pkg::*;
  logic             pclk, presetn, pready, pslverr, sign_a, sign_b, chain_ok, err;
  logic [31:0]      prdata, rd;
  logic [3:0]       ena, aclr;
  logic [1:0]       addnsub, accum_sload, overflow, prev_ad;
  logic [3:0][17:0] opa, opb;
  logic [35:0]      x, y;
  logic [71:0]      w;
  logic [52:0]      acc [2];
  apb_req_s         req;
  prod_t            prod;
  lanes_t           result;
  int               mismatches = 0;
  int               samples_checked = 0;
  dsp_out_stage dsp_out_stage_i (.pclk(pclk), .presetn(presetn), .apb(req), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .prod(prod), .ena(ena), .aclr(aclr), .sign_a(sign_a), .sign_b(sign_b),
    .addnsub(addnsub), .accum_sload(accum_sload), .result(result), .overflow(overflow), .chain_ok(chain_ok));
  mult_src mult_src_i (.a(opa), .b(opb), .sign_a(sign_a), .sign_b(sign_b), .prod(prod));
  always #2 pclk = ~pclk;
  task automatic chk(string nm, logic [51:0] seen, logic [51:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(logic wr, logic [11:0] ad, logic [31:0] wd);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: ad, pwdata: wd};
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic roll(logic sg, logic [1:0] ad);
    @(posedge pclk);
    opa <= 72'({$urandom, $urandom, $urandom});
    opb <= 72'({$urandom, $urandom, $urandom});
    sign_a <= sg & 1'($urandom);
    sign_b <= sg & 1'($urandom);
    addnsub <= ad;
  endtask
  task automatic settle();
    @(posedge pclk);
    #1;
  endtask
  function automatic logic [51:0] pe(int k);
    logic signed [37:0] f;
    f = $signed({sign_a & opa[k][17], opa[k]}) * $signed({sign_b & opb[k][17], opb[k]});
    return (sign_a | sign_b) ? 52'($signed(f[35:0])) : 52'(f[35:0]);
  endfunction
  function automatic logic [51:0] pm(logic [51:0] p, logic [51:0] q, logic ad);
    return ad ? p + q : p - q;
  endfunction
  // One half of a product lane, extended as a 9x9 result.
  function automatic logic [51:0] ph(int k, int h);
    logic [51:0] p;
    p = pe(k);
    return (sign_a | sign_b) ? 52'($signed(p[18*h +: 18])) : 52'(p[18*h +: 18]);
  endfunction
  function automatic logic [51:0] q9(int k, logic ad);
    return pm(ph(k, 0), ph(k, 1), ad);
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #80000;
    mismatches++;
    give_verdict();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    req = '0;
    opa = '0;
    opb = '0;
    {ena, aclr, sign_a, sign_b, addnsub, accum_sload} = '0;
    void'($urandom(32'hc22f6bc3));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    bus(1'b0, 12'h000, 32'h0);
    chk("ctrl", 52'(rd), 52'h4);
    bus(1'b0, 12'h100, 32'h0);
    chk("unmapped", 52'({err, rd}), 52'h100000000);
    $display("registers done");
    for (int i = 0; i < 6; i++) begin
      roll(1'b0, 2'b11);
      settle();
      for (int k = 0; k < 4; k++) chk("simple", result[k], pe(k));
    end
    $display("simple done");
    bus(1'b1, 12'h000, 32'h8);
    x = 36'({$urandom, $urandom});
    y = 36'({$urandom, $urandom});
    w = x * y;
    @(posedge pclk);
    opa <= {x[35:18], x[17:0], x[35:18], x[17:0]};
    opb <= {y[35:18], y[35:18], y[17:0], y[17:0]};
    settle();
    chk("chain", 52'(chain_ok), 52'h0);
    chk("wide_lo", result[0], 52'(w[35:0]));
    chk("wide_hi", result[1], 52'(w[71:36]));
    bus(1'b1, 12'h000, 32'h808);
    ena <= 4'h1;
    settle();
    chk("pipe_lag", result[0], 52'h0);
    settle();
    chk("pipe_lo", result[0], 52'(w[35:0]));
    chk("pipe_hi", result[1], 52'(w[71:36]));
    $display("wide done");
    for (int m = 2; m < 8; m++) begin
      if (m == 4 || m == 5) continue;
      bus(1'b1, 12'h000, 32'(m));
      accum_sload <= 2'b11;
      for (int i = 0; i < 6; i++) begin
        roll(1'b1, 2'($urandom));
        settle();
        chk("ovf_idle", 52'(overflow), 52'h0);
        if (m == 6) begin
          chk("pair0", result[0], pm(pe(0), pe(1), addnsub[0]));
          chk("pair1", result[1], pm(pe(2), pe(3), addnsub[1]));
        end else if (m == 7) begin
          chk("sum4", result[0], pm(pe(0), pe(1), addnsub[0]) + pm(pe(2), pe(3), addnsub[1]));
        end else if (m == 2) begin
          for (int k = 0; k < 4; k++) chk("pair9", result[k], q9(k, addnsub[k / 2]));
        end else begin
          chk("sum9_0", result[0], q9(0, addnsub[0]) + q9(1, addnsub[0]));
          chk("sum9_1", result[1], q9(2, addnsub[1]) + q9(3, addnsub[1]));
        end
      end
    end
    $display("adder modes done");
    bus(1'b1, 12'h000, 32'h26);
    ena <= 4'h1;
    for (int i = 0; i < 6; i++) begin
      prev_ad = addnsub;
      roll(1'b0, 2'($urandom));
      settle();
      chk("stage0", result[0], pm(pe(0), pe(1), prev_ad[0]));
      chk("stage1", result[1], pm(pe(2), pe(3), prev_ad[1]));
    end
    $display("control stage done");
    bus(1'b1, 12'h000, 32'h5);
    ena <= 4'h1;
    roll(1'b0, 2'b11);
    settle();
    for (int j = 0; j < 2; j++) begin
      acc[j] = {1'b0, pe(2 * j + 1)};
      chk("load", result[j], acc[j][51:0]);
    end
    for (int i = 0; i < 6; i++) begin
      roll(1'b0, i == 0 ? 2'b00 : 2'($urandom));
      accum_sload <= 2'b00;
      ena <= 4'(i != 5);
      // Enable only the edge that takes this product, so each product but the last is summed once.
      @(posedge pclk);
      ena <= 4'h0;
      #1;
      for (int j = 0; j < 2; j++) begin
        if (i != 5) acc[j] = addnsub[j] ? {1'b0, acc[j][51:0]} + {1'b0, pe(2 * j + 1)}
                                        : {1'b0, acc[j][51:0]} - {1'b0, pe(2 * j + 1)};
        chk("acc", result[j], acc[j][51:0]);
        if (i != 5) chk("ovf", 52'(overflow[j]), 52'(acc[j][52]));
      end
    end
    @(posedge pclk);
    ena <= 4'h1;
    aclr <= 4'h1;
    settle();
    chk("clear", result[0], 52'h0);
    bus(1'b0, 12'h004, 32'h0);
    chk("oreg", 52'(rd[2]), 52'h1);
    $display("accumulate done");
    give_verdict();
  end
endmodule
